// [ulmcs_params.svh]
// offsets, bit positions, reset values and timing counts of the line/modem block
`ifndef ULMCS_PARAMS_SVH
`define ULMCS_PARAMS_SVH
// ****************
// register offsets
// ****************
`define ULMCS_OFS_DATA   3'h0
`define ULMCS_OFS_IER    3'h1
`define ULMCS_OFS_FCR    3'h2
`define ULMCS_OFS_LCR    3'h3
`define ULMCS_OFS_MCR    3'h4
`define ULMCS_OFS_LSR    3'h5
`define ULMCS_OFS_MSR    3'h6
`define ULMCS_OFS_EXT    3'h7
// ****************
// field positions
// ****************
`define ULMCS_LCR_PEN    3
`define ULMCS_LCR_EPS    4
`define ULMCS_LCR_STICK  5
`define ULMCS_LCR_BRK    6
`define ULMCS_LCR_DLAB   7
`define ULMCS_MCR_DTR    0
`define ULMCS_MCR_RTS    1
`define ULMCS_MCR_OUT1   2
`define ULMCS_MCR_OUT2   3
`define ULMCS_MCR_LOOP   4
`define ULMCS_MCR_XANY   5
`define ULMCS_MCR_IRDA   6
`define ULMCS_MCR_PRESC  7
`define ULMCS_MCR_ENH_MASK 8'hE4
`define ULMCS_EXT_FLOW   0
`define ULMCS_EXT_ENH    4
`define ULMCS_FCR_EN     0
`define ULMCS_FCR_RXRST  1
`define ULMCS_FCR_TXRST  2
`define ULMCS_IER_RX     0
`define ULMCS_IER_TX     1
`define ULMCS_IER_LS     2
`define ULMCS_IER_MS     3
// ****************
// reset values
// ****************
`define ULMCS_LCR_RST    8'h00
`define ULMCS_MCR_RST    8'h00
`define ULMCS_EXT_RST    8'h00
`define ULMCS_IER_RST    4'h0
`define ULMCS_DIV_RST    16'h0000
`define ULMCS_SYNC_RST   7'h3F
// ****************
// timing and characters
// ****************
`define ULMCS_PH_LAST    4'hF
`define ULMCS_PH_HALF    4'h7
`define ULMCS_IR_PULSE   4'h3
`define ULMCS_IR_HOLD    5'h10
`define ULMCS_PRESC_LAST 2'h3
`define ULMCS_XON        8'h11
`define ULMCS_XOFF       8'h13
`endif

// [ulmcs_pkg.sv]
// types shared by the line/modem block
package ulmcs_pkg;
  typedef struct packed {
    logic       brk;
    logic       frm;
    logic       par;
    logic [7:0] data;
  } ulmcs_rx_entry_t;

  typedef struct packed {
    logic cd;
    logic ri;
    logic dsr;
    logic cts;
  } ulmcs_modem_t;

  typedef enum logic [4:0] {
    TX_IDLE  = 5'b00001,
    TX_START = 5'b00010,
    TX_DATA  = 5'b00100,
    TX_PAR   = 5'b01000,
    TX_STOP  = 5'b10000
  } ulmcs_tx_state_t;

  typedef enum logic [5:0] {
    RX_IDLE  = 6'b000001,
    RX_START = 6'b000010,
    RX_DATA  = 6'b000100,
    RX_PAR   = 6'b001000,
    RX_STOP  = 6'b010000,
    RX_WAITH = 6'b100000
  } ulmcs_rx_state_t;
endpackage : ulmcs_pkg

// [ulmcs_top.sv]
// uart line format, modem control and status logic
// What this block does
// - parity enable adds a transmit parity bit and checks received parity.
// - parity select zero gives odd parity, one gives even, both directions.
// - forced parity sends and expects one when select is zero, else zero.
// - break bit holds the serial output low until software clears it; in loopback or infrared mode the serial output stays high.
// - divisor access bit swaps data registers for divisor latches.
// - terminal-ready and request-to-send bits drive inverted active-low pins.
// - with infrared and enhanced mode, bit 2 selects infrared receive polarity.
// - in separate-pin bus mode, bit 3 enables the interrupt output driver.
// - loopback bit puts the device into internal local loopback.
// - in loopback, general outputs drive ring and carrier status bits.
// - resume-on-any restarts a flow-stopped transmitter on any received character except XOFF.
// - infrared bit routes data through encoder/decoder; transmit output idles low.
// - prescaler bit divides the baud generator input clock by four.
// - data-ready reads one while any received character is held.
// - character arriving at full receive storage sets overrun, storage untouched.
// - parity error status belongs to the character at the read head.
// - framing error status belongs to the character at the read head.
// - frame-long low line flags break, stores one character, waits for high.
// - holding-empty sets when the byte leaves, clears on host load.
// - transmitter-empty only when holding storage and shifter are both empty.
// - error summary is OR of errors over all stored receive bytes.
// - clear-to-send and data-set-ready deltas flag changes and request interrupts.
// - reading line status clears line interrupt; summary stays until bytes read.
// - reading modem status clears the modem status interrupt.
// - modem bits 2, 5, 6, 7 writable only with enhanced enable set.
// - in loopback, clear-to-send status follows request-to-send bit.
//
// Added by the designer: the register offsets and strobed register access.
`include "ulmcs_params.svh"
module ulmcs_top #(
  parameter int DEPTH = 16
) (
  input  wire logic                    clk_in,
  input  wire logic                    reset_in,
  input  wire logic [2:0]              addr_in,
  input  wire logic [7:0]              wr_data_in,
  input  wire logic                    wr_in,
  input  wire logic                    rd_in,
  output logic      [7:0]              rd_data_out,
  input  wire logic                    rx_in,
  output logic                         tx_out,
  input  wire logic                    ir_rx_in,
  output logic                         ir_tx_out,
  input  wire ulmcs_pkg::ulmcs_modem_t modem_n_in,
  output logic                         dtr_n_out,
  output logic                         rts_n_out,
  output logic                         general_output_one_n_out,
  output logic                         general_output_two_n_out,
  input  wire logic                    bus_mode_in,
  output logic                         irq_out,
  output logic                         irq_oe_out
);
  import ulmcs_pkg::*;
  localparam int AW = $clog2(DEPTH);

  function automatic logic par_bit(input logic [7:0] d, input logic [7:0] line_format_control);
    par_bit = line_format_control[`ULMCS_LCR_STICK] ? ~line_format_control[`ULMCS_LCR_EPS] :
              (line_format_control[`ULMCS_LCR_EPS] ? ^d : ~^d);
  endfunction : par_bit

  // ****************
  // pin synchronisers
  // ****************
  logic [6:0] sync1_r;
  logic [6:0] sync2_r;
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      sync1_r <= `ULMCS_SYNC_RST;
      sync2_r <= `ULMCS_SYNC_RST;
    end else begin
      sync1_r <= {bus_mode_in, ir_rx_in, rx_in, modem_n_in};
      sync2_r <= sync1_r;
    end
  end
  ulmcs_modem_t modem_s;
  wire logic    rx_s  = sync2_r[4];
  wire logic    ir_s  = sync2_r[5];
  wire logic    bus_s = sync2_r[6];
  assign modem_s = sync2_r[3:0];

  // ****************
  // register decode
  // ****************
  logic [7:0]  lcr_r;
  logic [7:0]  mcr_r;
  logic [7:0]  ext_r;
  logic [3:0]  ier_r;
  logic [15:0] div_r;
  logic        fifo_en_r;
  wire logic dlab    = lcr_r[`ULMCS_LCR_DLAB];
  wire logic loop    = mcr_r[`ULMCS_MCR_LOOP];
  wire logic irda    = mcr_r[`ULMCS_MCR_IRDA];
  wire logic enh     = ext_r[`ULMCS_EXT_ENH];
  wire logic at_data = addr_in == `ULMCS_OFS_DATA;
  wire logic at_ier  = addr_in == `ULMCS_OFS_IER;
  wire logic wr_thr  = wr_in && at_data && !dlab;
  wire logic wr_dll  = wr_in && at_data && dlab;
  wire logic wr_dlm  = wr_in && at_ier && dlab;
  wire logic wr_ier  = wr_in && at_ier && !dlab;
  wire logic wr_fcr  = wr_in && addr_in == `ULMCS_OFS_FCR;
  wire logic wr_lcr  = wr_in && addr_in == `ULMCS_OFS_LCR;
  wire logic wr_mcr  = wr_in && addr_in == `ULMCS_OFS_MCR;
  wire logic wr_ext  = wr_in && addr_in == `ULMCS_OFS_EXT;
  wire logic rd_rhr  = rd_in && at_data && !dlab;
  wire logic rd_lsr  = rd_in && addr_in == `ULMCS_OFS_LSR;
  wire logic rd_msr  = rd_in && addr_in == `ULMCS_OFS_MSR;
  wire logic [7:0] mcr_keep = enh ? 8'h00 : `ULMCS_MCR_ENH_MASK;
  wire logic [7:0] mcr_wr   = (wr_data_in & ~mcr_keep) | (mcr_r & mcr_keep);
  wire logic fcr_go   = wr_fcr && wr_data_in[`ULMCS_FCR_EN];
  wire logic rx_clr   = fcr_go && wr_data_in[`ULMCS_FCR_RXRST];
  wire logic tx_clr   = fcr_go && wr_data_in[`ULMCS_FCR_TXRST];

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      lcr_r     <= `ULMCS_LCR_RST;
      mcr_r     <= `ULMCS_MCR_RST;
      ext_r     <= `ULMCS_EXT_RST;
      ier_r     <= `ULMCS_IER_RST;
      div_r     <= `ULMCS_DIV_RST;
      fifo_en_r <= 1'b0;
    end else begin
      if (wr_lcr) lcr_r <= wr_data_in;
      if (wr_mcr) mcr_r <= mcr_wr;
      if (wr_ext) ext_r <= wr_data_in;
      if (wr_ier) ier_r <= wr_data_in[3:0];
      if (wr_dll) div_r[7:0] <= wr_data_in;
      if (wr_dlm) div_r[15:8] <= wr_data_in;
      if (wr_fcr) fifo_en_r <= wr_data_in[`ULMCS_FCR_EN];
    end
  end

  // ****************
  // baud generator
  // ****************
  logic [1:0]  pre_cnt_r;
  logic [15:0] div_cnt_r;
  logic [3:0]  ph_r;
  wire logic pre_tick = !mcr_r[`ULMCS_MCR_PRESC] || pre_cnt_r == `ULMCS_PRESC_LAST;
  wire logic div_end  = div_cnt_r >= div_r - 16'h0001;
  wire logic tick     = pre_tick && div_r != 16'h0000 && div_end;
  wire logic bit_end  = tick && ph_r == `ULMCS_PH_LAST;
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      pre_cnt_r <= 2'h0;
      div_cnt_r <= 16'h0000;
      ph_r      <= 4'h0;
    end else begin
      pre_cnt_r <= pre_cnt_r + 2'h1;
      if (pre_tick) div_cnt_r <= div_end ? 16'h0000 : div_cnt_r + 16'h0001;
      if (tick) ph_r <= ph_r + 4'h1;
    end
  end

  // ****************
  // transmit storage
  // ****************
  logic [7:0]      txq [DEPTH];
  logic [AW-1:0]   tx_wp_r;
  logic [AW-1:0]   tx_rp_r;
  logic [AW:0]     tx_cnt_r;
  ulmcs_tx_state_t tx_st_r;
  logic            tx_stop_r;
  wire logic [AW:0] cap   = fifo_en_r ? (AW+1)'(DEPTH) : (AW+1)'(1);
  wire logic tx_push = wr_thr && tx_cnt_r < cap;
  wire logic tx_go   = tx_cnt_r != '0 && !tx_stop_r;
  wire logic tx_pop  = bit_end && tx_st_r == TX_IDLE && tx_go;
  always_ff @(posedge clk_in) begin
    if (reset_in || tx_clr) begin
      tx_wp_r  <= '0;
      tx_rp_r  <= '0;
      tx_cnt_r <= '0;
    end else begin
      if (tx_push) txq[tx_wp_r] <= wr_data_in;
      if (tx_push) tx_wp_r <= tx_wp_r + 1'b1;
      if (tx_pop) tx_rp_r <= tx_rp_r + 1'b1;
      tx_cnt_r <= tx_cnt_r + (AW+1)'(tx_push) - (AW+1)'(tx_pop);
    end
  end

  // ****************
  // transmit shifter
  // ****************
  logic [7:0] tx_sh_r;
  logic [2:0] tx_bit_r;
  logic       tx_par_r;
  logic       tx_line_r;
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      tx_st_r   <= TX_IDLE;
      tx_sh_r   <= 8'h00;
      tx_bit_r  <= 3'h0;
      tx_par_r  <= 1'b0;
      tx_line_r <= 1'b1;
    end else if (bit_end) begin
      case (tx_st_r)
        TX_IDLE: if (tx_go) begin
          tx_sh_r   <= txq[tx_rp_r];
          tx_par_r  <= par_bit(txq[tx_rp_r], lcr_r);
          tx_line_r <= 1'b0;
          tx_st_r   <= TX_START;
        end
        TX_START: begin
          tx_line_r <= tx_sh_r[0];
          tx_bit_r  <= 3'h0;
          tx_st_r   <= TX_DATA;
        end
        TX_DATA: if (tx_bit_r == 3'h7) begin
          tx_st_r   <= lcr_r[`ULMCS_LCR_PEN] ? TX_PAR : TX_STOP;
          tx_line_r <= lcr_r[`ULMCS_LCR_PEN] ? tx_par_r : 1'b1;
        end else begin
          tx_sh_r   <= {1'b0, tx_sh_r[7:1]};
          tx_line_r <= tx_sh_r[1];
          tx_bit_r  <= tx_bit_r + 3'h1;
        end
        TX_PAR: begin
          tx_line_r <= 1'b1;
          tx_st_r   <= TX_STOP;
        end
        TX_STOP: tx_st_r <= TX_IDLE;
        default: tx_st_r <= TX_IDLE;
      endcase
    end
  end
  wire logic tx_eff = lcr_r[`ULMCS_LCR_BRK] ? 1'b0 : tx_line_r;

  // ****************
  // receive front end
  // ****************
  logic [4:0] ir_cnt_r;
  wire logic ir_inv   = mcr_r[`ULMCS_MCR_OUT1] && irda && enh;
  wire logic ir_pulse = ir_inv ? ir_s : !ir_s;
  wire logic rx_line  = loop ? tx_eff : (irda ? ir_cnt_r == 5'h00 : rx_s);
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ir_cnt_r <= 5'h00;
    end else if (ir_pulse && irda && !loop) begin
      ir_cnt_r <= `ULMCS_IR_HOLD;
    end else if (tick && ir_cnt_r != 5'h00) begin
      ir_cnt_r <= ir_cnt_r - 5'h01;
    end
  end

  // ****************
  // receive shifter
  // ****************
  ulmcs_rx_state_t rx_st_r;
  logic [3:0]      rx_ph_r;
  logic [2:0]      rx_bit_r;
  logic [7:0]      rx_sh_r;
  logic            rx_zero_r;
  logic            rx_pe_r;
  ulmcs_rx_entry_t rx_new;
  wire logic rx_smp  = tick && rx_ph_r == `ULMCS_PH_LAST;
  wire logic rx_done = rx_smp && rx_st_r == RX_STOP;
  assign rx_new.brk  = rx_zero_r && !rx_line;
  assign rx_new.frm  = !rx_line;
  assign rx_new.par  = rx_pe_r;
  assign rx_new.data = rx_sh_r;
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rx_st_r   <= RX_IDLE;
      rx_ph_r   <= 4'h0;
      rx_bit_r  <= 3'h0;
      rx_sh_r   <= 8'h00;
      rx_zero_r <= 1'b0;
      rx_pe_r   <= 1'b0;
    end else begin
      if (tick) rx_ph_r <= rx_ph_r + 4'h1;
      case (rx_st_r)
        RX_IDLE: if (!rx_line) begin
          rx_ph_r <= 4'h0;
          rx_st_r <= RX_START;
        end
        RX_START: if (tick && rx_ph_r == `ULMCS_PH_HALF) begin
          rx_ph_r   <= 4'h0;
          rx_bit_r  <= 3'h0;
          rx_zero_r <= 1'b1;
          rx_pe_r   <= 1'b0;
          rx_st_r   <= rx_line ? RX_IDLE : RX_DATA;
        end
        RX_DATA: if (rx_smp) begin
          rx_sh_r   <= {rx_line, rx_sh_r[7:1]};
          rx_zero_r <= rx_zero_r && !rx_line;
          rx_bit_r  <= rx_bit_r + 3'h1;
          if (rx_bit_r == 3'h7) rx_st_r <= lcr_r[`ULMCS_LCR_PEN] ? RX_PAR : RX_STOP;
        end
        RX_PAR: if (rx_smp) begin
          rx_pe_r   <= rx_line != par_bit(rx_sh_r, lcr_r);
          rx_zero_r <= rx_zero_r && !rx_line;
          rx_st_r   <= RX_STOP;
        end
        RX_STOP: if (rx_smp) rx_st_r <= rx_new.brk ? RX_WAITH : RX_IDLE;
        RX_WAITH: if (rx_line) rx_st_r <= RX_IDLE;
        default: rx_st_r <= RX_IDLE;
      endcase
    end
  end

  // ****************
  // software flow stop
  // ****************
  wire logic flow_on = ext_r[`ULMCS_EXT_FLOW];
  wire logic is_xon  = rx_new.data == `ULMCS_XON && !rx_new.brk;
  wire logic is_xoff = rx_new.data == `ULMCS_XOFF && !rx_new.brk;
  wire logic rx_keep = !(flow_on && (is_xon || is_xoff));
  wire logic resume  = rx_done && (is_xon || mcr_r[`ULMCS_MCR_XANY]);
  always_ff @(posedge clk_in) begin
    if (reset_in || !flow_on) begin
      tx_stop_r <= 1'b0;
    end else if (rx_done && is_xoff) begin
      tx_stop_r <= 1'b1;
    end else if (resume) begin
      tx_stop_r <= 1'b0;
    end
  end

  // ****************
  // receive storage
  // ****************
  ulmcs_rx_entry_t rxq [DEPTH];
  logic [AW-1:0]   rx_wp_r;
  logic [AW-1:0]   rx_rp_r;
  logic [AW:0]     rx_cnt_r;
  logic [AW:0]     err_cnt_r;
  logic            ovr_r;
  logic            line_int_r;
  ulmcs_rx_entry_t rx_head;
  wire logic rx_full  = rx_cnt_r >= cap;
  wire logic rx_ready = rx_cnt_r != '0;
  wire logic rx_push  = rx_done && rx_keep && !rx_full;
  wire logic ovr_set  = rx_done && rx_keep && rx_full;
  wire logic rx_pop   = rd_rhr && rx_ready;
  wire logic new_err  = rx_new.brk || rx_new.frm || rx_new.par;
  assign rx_head = rx_ready ? rxq[rx_rp_r] : '0;
  wire logic head_err = rx_head.brk || rx_head.frm || rx_head.par;
  always_ff @(posedge clk_in) begin
    if (reset_in || rx_clr) begin
      rx_wp_r   <= '0;
      rx_rp_r   <= '0;
      rx_cnt_r  <= '0;
      err_cnt_r <= '0;
    end else begin
      if (rx_push) rxq[rx_wp_r] <= rx_new;
      if (rx_push) rx_wp_r <= rx_wp_r + 1'b1;
      if (rx_pop) rx_rp_r <= rx_rp_r + 1'b1;
      rx_cnt_r  <= rx_cnt_r + (AW+1)'(rx_push) - (AW+1)'(rx_pop);
      err_cnt_r <= err_cnt_r + (AW+1)'(rx_push && new_err)
                             - (AW+1)'(rx_pop && head_err);
    end
  end
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ovr_r      <= 1'b0;
      line_int_r <= 1'b0;
    end else begin
      ovr_r      <= ovr_set || (ovr_r && !rd_lsr);
      line_int_r <= ovr_set || (rx_push && new_err) || (line_int_r && !rd_lsr);
    end
  end
  wire logic thre = tx_cnt_r == '0;
  wire logic temt = thre && tx_st_r == TX_IDLE;
  wire logic [7:0] lsr_val = {err_cnt_r != '0, temt, thre, rx_head.brk,
                              rx_head.frm, rx_head.par, ovr_r, rx_ready};

  // ****************
  // modem status
  // ****************
  ulmcs_modem_t stat;
  ulmcs_modem_t prev_r;
  logic [3:0]   delta_r;
  assign stat.cts = loop ? mcr_r[`ULMCS_MCR_RTS] : !modem_s.cts;
  assign stat.dsr = loop ? mcr_r[`ULMCS_MCR_DTR] : !modem_s.dsr;
  assign stat.ri  = loop ? mcr_r[`ULMCS_MCR_OUT1] : !modem_s.ri;
  assign stat.cd  = loop ? mcr_r[`ULMCS_MCR_OUT2] : !modem_s.cd;
  wire logic [3:0] delta_set = {stat.cd != prev_r.cd, prev_r.ri && !stat.ri,
                                stat.dsr != prev_r.dsr, stat.cts != prev_r.cts};
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      prev_r  <= '0;
      delta_r <= 4'h0;
    end else begin
      prev_r  <= stat;
      delta_r <= (rd_msr ? 4'h0 : delta_r) | delta_set;
    end
  end
  wire logic [7:0] msr_val = {stat, delta_r};

  // ****************
  // interrupt and read
  // ****************
  wire logic irq_lvl = (ier_r[`ULMCS_IER_LS] && line_int_r) ||
                       (ier_r[`ULMCS_IER_MS] && delta_r != 4'h0) ||
                       (ier_r[`ULMCS_IER_RX] && rx_ready) ||
                       (ier_r[`ULMCS_IER_TX] && thre);
  wire logic [7:0] isr_val = {fifo_en_r, fifo_en_r, 5'h00, !irq_lvl};
  wire logic [7:0] data_rd = dlab ? div_r[7:0] : rx_head.data;
  wire logic [7:0] ier_rd  = dlab ? div_r[15:8] : {4'h0, ier_r};
  wire logic [7:0] rd_mux  =
    (addr_in == `ULMCS_OFS_DATA) ? data_rd :
    (addr_in == `ULMCS_OFS_IER)  ? ier_rd :
    (addr_in == `ULMCS_OFS_FCR)  ? isr_val :
    (addr_in == `ULMCS_OFS_LCR)  ? lcr_r :
    (addr_in == `ULMCS_OFS_MCR)  ? mcr_r :
    (addr_in == `ULMCS_OFS_LSR)  ? lsr_val :
    (addr_in == `ULMCS_OFS_MSR)  ? msr_val : ext_r;

  // ****************
  // output flops
  // ****************
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rd_data_out              <= 8'h00;
      tx_out                   <= 1'b1;
      ir_tx_out                <= 1'b0;
      dtr_n_out                <= 1'b1;
      rts_n_out                <= 1'b1;
      general_output_one_n_out <= 1'b1;
      general_output_two_n_out <= 1'b1;
      irq_out                  <= 1'b0;
      irq_oe_out               <= 1'b0;
    end else begin
      rd_data_out              <= rd_in ? rd_mux : 8'h00;
      tx_out                   <= loop || irda || tx_eff;
      ir_tx_out                <= irda && !loop && !tx_eff && ph_r < `ULMCS_IR_PULSE;
      dtr_n_out                <= loop || !mcr_r[`ULMCS_MCR_DTR];
      rts_n_out                <= loop || !mcr_r[`ULMCS_MCR_RTS];
      general_output_one_n_out <= loop || !mcr_r[`ULMCS_MCR_OUT1];
      general_output_two_n_out <= loop || !mcr_r[`ULMCS_MCR_OUT2];
      irq_out                  <= irq_lvl;
      irq_oe_out               <= bus_s ? mcr_r[`ULMCS_MCR_OUT2] : 1'b1;
    end
  end
endmodule : ulmcs_top

// [ulmcs_top_props.sv]
// assertions on the ports of the line/modem block
module ulmcs_chk (
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  input  wire logic [2:0] addr_in,
  input  wire logic [7:0] wr_data_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  input  wire logic [7:0] rd_data_out,
  input  wire logic       tx_out,
  input  wire logic       dtr_n_out,
  input  wire logic       rts_n_out,
  input  wire logic       general_output_two_n_out,
  input  wire logic       bus_mode_in,
  input  wire logic       irq_oe_out
);
  // ****
  // register shadows
  // ****
  logic [7:0] lcr_r;
  logic [7:0] mcr_r;
  logic [7:0] dll_r;
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      lcr_r <= 8'h00;
      mcr_r <= 8'h00;
      dll_r <= 8'h00;
    end else if (wr_in) begin
      if (addr_in == 3'h3) lcr_r <= wr_data_in;
      if (addr_in == 3'h4) mcr_r <= wr_data_in & 8'h1B;
      if (addr_in == 3'h0 && lcr_r[7]) dll_r <= wr_data_in;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  property p_brk; lcr_r[6] && $past(lcr_r[6]) && !$past(mcr_r[4]) |-> !tx_out; endproperty
  a_brk: assert property (p_brk) else $error("tx not low in break");
  property p_dtr; !$past(reset_in) |-> dtr_n_out == ($past(mcr_r[4]) | !$past(mcr_r[0]));
  endproperty
  a_dtr: assert property (p_dtr) else $error("dtr pin wrong");
  property p_rts; !$past(reset_in) |-> rts_n_out == ($past(mcr_r[4]) | !$past(mcr_r[1]));
  endproperty
  a_rts: assert property (p_rts) else $error("rts pin wrong");
  // strap passes two sync flops and the output flop
  property p_oe; !$past(reset_in, 3) |->
    irq_oe_out == (!$past(bus_mode_in, 3) | $past(mcr_r[3]));
  endproperty
  a_oe: assert property (p_oe) else $error("irq enable wrong");
  property p_dll; rd_in && addr_in == 3'h0 && lcr_r[7] |=> rd_data_out == $past(dll_r);
  endproperty
  a_dll: assert property (p_dll) else $error("divisor read wrong");
  property p_lcr; rd_in && addr_in == 3'h3 |=> rd_data_out == $past(lcr_r); endproperty
  a_lcr: assert property (p_lcr) else $error("line format read wrong");
  property p_ltx; mcr_r[4] && $past(mcr_r[4]) && !lcr_r[6] |-> tx_out; endproperty
  a_ltx: assert property (p_ltx) else $error("tx not idle in loopback");
  property p_op2; !$past(reset_in) |-> general_output_two_n_out ==
    ($past(mcr_r[4]) | !$past(mcr_r[3]));
  endproperty
  a_op2: assert property (p_op2) else $error("general output wrong");
  c_brk: cover property (lcr_r[6] && !tx_out);
  c_loop: cover property (mcr_r[4] && rd_in && addr_in == 3'h6);
  c_dll: cover property (rd_in && addr_in == 3'h0 && lcr_r[7]);
endmodule : ulmcs_chk
bind ulmcs_top ulmcs_chk u_chk (.clk_in, .reset_in, .addr_in, .wr_data_in, .wr_in, .rd_in,
  .rd_data_out, .tx_out, .dtr_n_out, .rts_n_out, .general_output_two_n_out, .bus_mode_in,
  .irq_oe_out);

// [ulmcs_modem_model.sv]
// serial and modem line model of the far side
module ulmcs_modem_model
  import ulmcs_pkg::*;
(
  input  wire logic   clk_in,
  input  wire logic   tx_in,
  output logic        rx_out,
  output ulmcs_modem_t modem_n_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    rx_out = 1'b1;
    modem_n_out = 4'hF;
  end
  // lc is {force, even, enable}; bad flips parity, stp is the stop level
  task automatic send(input logic [7:0] d, input logic [2:0] lc, input logic bad,
                      input logic stp, input int bt);
    logic [10:0] f;
    logic        p;
    p = (lc[2] ? !lc[1] : (lc[1] ? ^d : ~^d)) ^ bad;
    f = lc[0] ? {stp, p, d, 1'b0} : {1'b1, stp, d, 1'b0};
    for (int i = 0; i < (lc[0] ? 11 : 10); i++) begin
      rx_out <= f[i];
      repeat (bt) @(posedge clk_in);
    end
    rx_out <= 1'b1;
    repeat (bt) @(posedge clk_in);
  endtask : send
  task automatic recv(output logic [7:0] d, output logic p, input int bt);
    @(negedge tx_in);
    repeat (bt / 2) @(posedge clk_in);
    for (int i = 0; i < 9; i++) begin
      repeat (bt) @(posedge clk_in);
      if (i < 8) d[i] = tx_in;
      else p = tx_in;
    end
  endtask : recv
endmodule : ulmcs_modem_model

// [uart_line_modem_control_status_test.sv]
// register and serial tests of the line/modem block
module uart_line_modem_control_status_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_in, reset_in, wr_in, rd_in, rx_in, tx_out, ir_tx_out, p, ep, bm, irq;
  logic [2:0] addr_in;
  logic [7:0] wr_data_in, rd_data_out, d, rdv;
  ulmcs_pkg::ulmcs_modem_t modem_n;
  logic [7:0] lcv [5] = '{8'h00, 8'h08, 8'h18, 8'h28, 8'h38};
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;
  ulmcs_top DUT (.clk_in, .reset_in, .addr_in, .wr_data_in, .wr_in, .rd_in, .rd_data_out,
    .rx_in, .tx_out, .ir_rx_in(1'b1), .ir_tx_out, .modem_n_in(modem_n), .dtr_n_out(),
    .rts_n_out(), .general_output_one_n_out(), .general_output_two_n_out(),
    .bus_mode_in(bm), .irq_out(irq), .irq_oe_out());
  ulmcs_modem_model m (.clk_in, .tx_in(tx_out), .rx_out(rx_in), .modem_n_out(modem_n));
  // ****
  // bus tasks
  // ****
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    addr_in <= a;
    wr_data_in <= v;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
    @(posedge clk_in);
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] k = 8'hFF);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 rdv = rd_data_out;
    chk(rdv & k, e);
    @(posedge clk_in);
  endtask : rd
  task stop_test;
    $display("errors=%0d tests=%0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = !clk_in;
  end
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      stop_test();
    end
  end
  // ****
  // tests
  // ****
  initial begin
    {reset_in, wr_in, rd_in, addr_in, wr_data_in} = {1'b1, 13'h0000};
    bm = 1'b1;
    repeat (3) @(posedge clk_in);
    reset_in <= 1'b0;
    @(posedge clk_in);
    rd(3'h3, 8'h00);
    rd(3'h5, 8'h60);
    rd(3'h6, 8'h00);
    wr(3'h4, 8'hE4);
    rd(3'h4, 8'h00);
    wr(3'h7, 8'h10);
    wr(3'h4, 8'h40);
    repeat (4) @(posedge clk_in);
    chk({6'h00, ir_tx_out, tx_out}, 8'h01);
    rd(3'h4, 8'h40);
    wr(3'h4, 8'h00);
    wr(3'h3, 8'h80);
    wr(3'h0, 8'h01);
    wr(3'h1, 8'h00);
    rd(3'h0, 8'h01);
    rd(3'h1, 8'h00);
    wr(3'h3, 8'h00);
    rd(3'h0, 8'h00);
    for (int i = 0; i < 5; i++) begin
      wr(3'h3, lcv[i]);
      m.send(8'hA7, lcv[i][5:3], 1'b0, 1'b1, 16);
      rd(3'h5, 8'h61);
      rd(3'h0, 8'hA7);
      if (lcv[i][3]) begin
        m.send(8'hA7, lcv[i][5:3], 1'b1, 1'b1, 16);
        rd(3'h5, 8'hE5);
        rd(3'h0, 8'hA7);
      end
      wr(3'h0, 8'hA7);
      m.recv(d, p, 16);
      ep = !lcv[i][3] | (lcv[i][5] ? !lcv[i][4] : (lcv[i][4] ? ^d : ~^d));
      chk({p, d}, {ep, 8'hA7});
      repeat (32) @(posedge clk_in);
    end
    wr(3'h3, 8'h00);
    m.send(8'h31, 3'h0, 1'b0, 1'b1, 16);
    m.send(8'h32, 3'h0, 1'b0, 1'b1, 16);
    rd(3'h5, 8'h63);
    rd(3'h0, 8'h31);
    rd(3'h5, 8'h60);
    m.send(8'h5C, 3'h0, 1'b0, 1'b0, 16);
    rd(3'h5, 8'hE9);
    rd(3'h0, 8'h5C);
    m.send(8'h00, 3'h0, 1'b0, 1'b0, 16);
    rd(3'h5, 8'hF9);
    rd(3'h0, 8'h00);
    rd(3'h5, 8'h60);
    wr(3'h3, 8'h40);
    repeat (40) @(posedge clk_in);
    chk({7'h00, tx_out}, 8'h00);
    wr(3'h3, 8'h00);
    wr(3'h1, 8'h08);
    m.modem_n_out <= 4'hE;
    repeat (8) @(posedge clk_in);
    chk({7'h00, irq}, 8'h01);
    rd(3'h6, 8'h11);
    rd(3'h6, 8'h10);
    repeat (2) @(posedge clk_in);
    chk({7'h00, irq}, 8'h00);
    m.modem_n_out <= 4'hC;
    repeat (8) @(posedge clk_in);
    rd(3'h6, 8'h32);
    m.modem_n_out <= 4'hF;
    repeat (8) @(posedge clk_in);
    rd(3'h6, 8'h03);
    rd(3'h6, 8'h00);
    wr(3'h4, 8'h1F);
    repeat (8) @(posedge clk_in);
    rd(3'h6, 8'hF0, 8'hF0);
    wr(3'h4, 8'h16);
    repeat (8) @(posedge clk_in);
    rd(3'h6, 8'h50, 8'hF0);
    wr(3'h0, 8'h3C);
    repeat (400) @(posedge clk_in);
    rd(3'h5, 8'h61);
    rd(3'h0, 8'h3C);
    wr(3'h4, 8'h80);
    m.send(8'h5C, 3'h0, 1'b0, 1'b1, 64);
    rd(3'h0, 8'h5C);
    bm <= 1'b0;
    repeat (6) @(posedge clk_in);
    stop_test();
  end
endmodule : uart_line_modem_control_status_test
